// *** bench/host_port_segment_addressing_tb.sv ***
// self-checking bench for the host port segment addressing block
// assumes hpsa_host_model plays the host on the port and memory side
`timescale 1ns/1ns
module host_port_segment_addressing_tb;
  localparam logic [15:0] STRAP = 16'h0070;
  localparam logic [15:0] WOFF = 16'h0006;
  localparam logic [15:0] WSEG = 16'hA5C3;
  logic clk, nrst, init_n, io_wr, io_addr_16, cvt_req, word_valid, cblk_q;
  logic ev_cmd_done, ev_cmd_suppress, ev_seek_done, ev_media_change;
  logic [15:0] io_addr, cvt_seg, cvt_off, word_data;
  logic [7:0] io_data, int_out_n;
  logic [2:0] int_jumper;
  logic [23:0] mem_addr, chan_addr;
  logic mem_addr_valid, ctrl_reset, diag_start, wake_fetch, iopb_fetch;
  logic busy_clear, shift_large, chan_valid, int_pending;
  logic [23:0] exp_q[$];
  int fails, check_count, seed, n_iopb, n_busy, n_diag;
  hpsa_host_port dut_u (.clk(clk), .nrst(nrst), .init_n(init_n),
    .io_wr(io_wr), .io_addr(io_addr), .io_data(io_data),
    .wake_address_straps(STRAP), .io_addr_16(io_addr_16),
    .int_jumper(int_jumper), .cvt_req(cvt_req), .cvt_seg(cvt_seg),
    .cvt_off(cvt_off), .word_valid(word_valid), .word_data(word_data),
    .ev_cmd_done(ev_cmd_done), .ev_cmd_suppress(ev_cmd_suppress),
    .ev_seek_done(ev_seek_done), .ev_media_change(ev_media_change),
    .mem_addr(mem_addr), .mem_addr_valid(mem_addr_valid),
    .ctrl_reset(ctrl_reset), .diag_start(diag_start),
    .wake_fetch(wake_fetch), .iopb_fetch(iopb_fetch),
    .busy_clear(busy_clear), .shift_large(shift_large),
    .channel_control_block_addr(chan_addr),
    .channel_control_block_valid(chan_valid), .int_out_n(int_out_n),
    .int_pending(int_pending));
  hpsa_host_model #(.WAKE_OFF(WOFF), .WAKE_SEG(WSEG)) host_u (.clk(clk),
    .wake_fetch(wake_fetch), .io_wr(io_wr), .io_addr(io_addr),
    .io_data(io_data), .word_valid(word_valid), .word_data(word_data));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [23:0] seg_addr(input logic [15:0] s, o,
                                           input logic big);
    seg_addr = ({8'h00, s} << (big ? 8 : 4)) + {8'h00, o};
  endfunction
  task automatic check(input string what, input logic [23:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic take(input string what, input logic [23:0] seen);
    if (exp_q.size() == 0)
      check({what, " unexpected"}, seen, ~seen);
    else
      check(what, seen, exp_q.pop_front());
  endtask
  always @(posedge clk) begin
    cblk_q <= chan_valid;
    n_iopb <= n_iopb + int'(iopb_fetch === 1'b1);
    n_busy <= n_busy + int'(busy_clear === 1'b1);
    n_diag <= n_diag + int'(diag_start === 1'b1);
    if (mem_addr_valid === 1'b1 || wake_fetch === 1'b1)
      take("mem_addr", mem_addr);
    if (chan_valid === 1'b1 && cblk_q !== 1'b1)
      take("chan_addr", chan_addr);
  end
  task automatic cvt(input logic [15:0] s, o, input logic big);
    @(posedge clk);
    cvt_req <= 1'b1;
    cvt_seg <= s;
    cvt_off <= o;
    exp_q.push_back(seg_addr(s, o, big));
  endtask
  task automatic idle;
    @(posedge clk);
    cvt_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic ev(input logic [3:0] e);
    @(posedge clk);
    {ev_cmd_done, ev_cmd_suppress, ev_seek_done, ev_media_change} <= e;
    @(posedge clk);
    {ev_cmd_done, ev_cmd_suppress, ev_seek_done, ev_media_change} <= 4'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic int_chk(input logic on);
    check("int_pending", {23'h0, int_pending}, {23'h0, on});
    check("int_out_n", {16'h0, int_out_n},
          on ? {16'h0, ~(8'h01 << int_jumper)} : 24'h0000FF);
  endtask
  task automatic first_start(input logic [7:0] d);
    exp_q.push_back(seg_addr(STRAP, 16'h0000, d[1]));
    exp_q.push_back(seg_addr(WSEG, WOFF, d[1]));
    host_u.io_write(STRAP, d);
    repeat (8) @(posedge clk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #600000;
    fails++;
    conclude();
  end
  initial begin
    {seed, fails, check_count, n_iopb, n_busy, n_diag} = '0;
    seed = 95264;
    {nrst, init_n, io_addr_16, cvt_req, cblk_q, int_jumper} = 8'h63;
    {ev_cmd_done, ev_cmd_suppress, ev_seek_done, ev_media_change} = 4'h0;
    {cvt_seg, cvt_off} = 32'h0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    check("held", {23'h0, ctrl_reset}, 24'h1);
    int_chk(1'b0);
    host_u.io_write(STRAP, 8'h01);
    cvt_req <= 1'b1;
    idle();
    host_u.io_write(STRAP, 8'h00);
    check("released", {23'h0, ctrl_reset}, 24'h0);
    check("diag", 24'(n_diag), 24'h1);
    first_start(8'h01);
    check("busy", 24'(n_busy), 24'h1);
    check("shift 01", {23'h0, shift_large}, 24'h0);
    $display("test reset and wake done");
    host_u.io_write(STRAP, 8'h03);
    check("shift 03", {23'h0, shift_large}, 24'h1);
    cvt(16'hFFFF, 16'hFFFF, 1'b1);
    repeat (6) cvt(16'($random(seed)), 16'($random(seed)), 1'b1);
    idle();
    host_u.io_write(STRAP, 8'hFD);
    check("shift FD", {23'h0, shift_large}, 24'h0);
    check("iopb", 24'(n_iopb), 24'h2);
    cvt(16'h1234, 16'h5678, 1'b0);
    cvt(16'h0123, 16'h0456, 1'b0);
    repeat (6) cvt(16'($random(seed)), 16'($random(seed)), 1'b0);
    idle();
    $display("test conversion done");
    int_jumper <= 3'($random(seed));
    ev(4'h8);
    int_chk(1'b1);
    host_u.io_write(STRAP ^ 16'h0100, 8'h00);
    int_chk(1'b1);
    io_addr_16 <= 1'b0;
    host_u.io_write(STRAP ^ 16'h0100, 8'h00);
    int_chk(1'b0);
    io_addr_16 <= 1'b1;
    ev(4'hC);
    int_chk(1'b0);
    ev(4'h1);
    int_chk(1'b1);
    host_u.io_write(STRAP, 8'h02);
    int_chk(1'b0);
    check("reset write", {23'h0, ctrl_reset}, 24'h1);
    host_u.io_write(STRAP, 8'h00);
    first_start(8'h03);
    check("busy again", 24'(n_busy), 24'h2);
    $display("test interrupt and reset write done");
    ev(4'h2);
    int_chk(1'b1);
    init_n <= 1'b0;
    repeat (4) @(posedge clk);
    init_n <= 1'b1;
    repeat (4) @(posedge clk);
    int_chk(1'b0);
    check("init", {23'h0, ctrl_reset}, 24'h1);
    check("left", 24'(exp_q.size()), 24'h0);
    $display("test init done");
    conclude();
  end
endmodule

// *** bench/hpsa_host_model.sv ***
// host processor model: port writes and wake block words from memory
// assumes the design pulses wake_fetch once for each wake block read
`timescale 1ns/1ns
module hpsa_host_model #(
  parameter logic [15:0] WAKE_OFF = 16'h0006,
  parameter logic [15:0] WAKE_SEG = 16'hA5C3
) (
  input wire logic clk,
  input wire logic wake_fetch,
  output logic io_wr,
  output logic [15:0] io_addr,
  output logic [7:0] io_data,
  output logic word_valid,
  output logic [15:0] word_data
);
  initial begin
    io_wr = 1'b0;
    io_addr = 16'h0000;
    io_data = 8'h00;
    word_valid = 1'b0;
    word_data = 16'h0000;
  end
  // held well past the strobe so the synchroniser sees stable lines
  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_data <= d;
    @(posedge clk);
    io_wr <= 1'b1;
    repeat (4) @(posedge clk);
    io_wr <= 1'b0;
    repeat (4) @(posedge clk);
    io_addr <= ~a;
    io_data <= ~d;
  endtask
  // wake block segment is 16-aligned, zero offset
  // offset word first, then segment word
  initial forever begin
    @(posedge clk);
    if (wake_fetch === 1'b1) begin
      repeat (2) @(posedge clk);
      word_valid <= 1'b1;
      word_data <= WAKE_OFF;
      @(posedge clk);
      word_data <= WAKE_SEG;
      @(posedge clk);
      word_valid <= 1'b0;
      word_data <= ~WAKE_SEG;
    end
  end
endmodule

// *** src/hpsa_cfg.svh ***
// constants for the host port segment addressing block
// assumes inclusion by bare name from the design file
`ifndef HPSA_CFG_SVH
`define HPSA_CFG_SVH
`define HPSA_FN_CLEAR 2'h0
`define HPSA_FN_START20 2'h1
`define HPSA_FN_RESET 2'h2
`define HPSA_FN_START24 2'h3
`define HPSA_SHIFT_SMALL 4
`define HPSA_SHIFT_LARGE 8
`define HPSA_ADDR_W 24
`define HPSA_IO_W 16
`define HPSA_INT_LINES 8
`endif

// *** src/hpsa_host_port.sv ***
// host port: programmed i/o decode, segment address conversion, interrupt
// assumes a bus front end that gives one-cycle io write and fetch strobes
//
// Behaviour
// [RULE_01] all addresses are computed and driven as full 24 bits
// [RULE_02] address is segment shifted left 4 or 8 plus offset
// [RULE_03] segmented addresses are fetched as segment and offset words
// [RULE_04] start with 01H selects 4-bit segment shift
// [RULE_05] start with 03H selects 8-bit segment shift
// [RULE_06] first start: wake-up address is strapped segment, zero offset
// [RULE_07] shift mode may change between successive starts
// [RULE_08] one strapped 8 or 16 bit port, io writes only
// [RULE_09] low two data bits select clear, start, reset, start
// [RULE_10] clear write drops any pending interrupt
// [RULE_11] device held in reset until a clear write arrives
// [RULE_12] first start fetches control-table addresses, only busy cleared
// [RULE_13] later starts fetch parameter block and run the command
// [RULE_14] reset write resets at once, ends operations, no status
// [RULE_15] clear release starts diagnostics; host must then init drives
// [RULE_16] interrupt drives one of eight lines picked by jumper
// [RULE_17] interrupt stays until clear, reset write, power-on or init
// [RULE_18] host keeps upper address bits zero on 16-bit systems
// [RULE_19] host aligns segment-addressed blocks to 16 or 256 bytes
// [RULE_20] wake-up block read once per reset, channel block address kept
// [RULE_21] interrupt on command, seek, media change; command one maskable
// [RULE_22] sum kept in 24 bits, carry out of bit 23 dropped
`timescale 1ns/1ns
`include "hpsa_cfg.svh"
module hpsa_host_port (
  input wire logic clk,
  input wire logic nrst,
  input wire logic init_n,
  input wire logic io_wr,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_data,
  input wire logic [15:0] wake_address_straps,
  input wire logic io_addr_16,
  input wire logic [2:0] int_jumper,
  input wire logic cvt_req,
  input wire logic [15:0] cvt_seg,
  input wire logic [15:0] cvt_off,
  input wire logic word_valid,
  input wire logic [15:0] word_data,
  input wire logic ev_cmd_done,
  input wire logic ev_cmd_suppress,
  input wire logic ev_seek_done,
  input wire logic ev_media_change,
  output logic [23:0] mem_addr,
  output logic mem_addr_valid,
  output logic ctrl_reset,
  output logic diag_start,
  output logic wake_fetch,
  output logic iopb_fetch,
  output logic busy_clear,
  output logic shift_large,
  output logic [23:0] channel_control_block_addr,
  output logic channel_control_block_valid,
  output logic [7:0] int_out_n,
  output logic int_pending
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: io pins and init come from the bus
  logic [1:0] wr_s;
  logic [1:0] init_s;
  logic [15:0] addr_s0, addr_s1;
  logic [7:0] data_s0, data_s1;
  logic wr_d;
  // straps and jumper are board pins as well; they settle long before use
  logic [15:0] strap_s0, strap_s1;
  logic [2:0] jmp_s0, jmp_s1;
  logic a16_s0, a16_s1;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_s <= 2'h0;
      init_s <= 2'h3;
      addr_s0 <= 16'h0000;
      addr_s1 <= 16'h0000;
      data_s0 <= 8'h00;
      data_s1 <= 8'h00;
      wr_d <= 1'b0;
      strap_s0 <= 16'h0000;
      strap_s1 <= 16'h0000;
      jmp_s0 <= 3'h0;
      jmp_s1 <= 3'h0;
      a16_s0 <= 1'b0;
      a16_s1 <= 1'b0;
    end else begin
      wr_s <= {wr_s[0], io_wr};
      init_s <= {init_s[0], init_n};
      addr_s0 <= io_addr;
      addr_s1 <= addr_s0;
      data_s0 <= io_data;
      data_s1 <= data_s0;
      wr_d <= wr_s[1];
      strap_s0 <= wake_address_straps;
      strap_s1 <= strap_s0;
      jmp_s0 <= int_jumper;
      jmp_s1 <= jmp_s0;
      a16_s0 <= io_addr_16;
      a16_s1 <= a16_s0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port decode; reads never reach this block
  logic port_hit;
  logic wr_edge;
  logic [1:0] fn;
  logic do_clear, do_start, do_reset;
  always_comb begin
    if (a16_s1) begin
      port_hit = (addr_s1 == strap_s1); // [RULE_08]
    end else begin
      port_hit = (addr_s1[7:0] == strap_s1[7:0]); // [RULE_08]
    end
  end
  assign wr_edge = wr_s[1] && !wr_d && port_hit;
  assign fn = data_s1[1:0]; // [RULE_09]
  assign do_clear = wr_edge && (fn == `HPSA_FN_CLEAR);
  assign do_reset = wr_edge && (fn == `HPSA_FN_RESET);
  assign do_start = wr_edge &&
    ((fn == `HPSA_FN_START20) || (fn == `HPSA_FN_START24));

  ////////////////////////////////////////////////////////////////////////////
  // reset hold and control state machine
  hpsa_pkg::hpsa_state_e state;
  logic hard_rst;
  assign hard_rst = !nrst || !init_s[1];
  assign ctrl_reset = (state == hpsa_pkg::HPSA_HELD); // [RULE_11]
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      state <= hpsa_pkg::HPSA_HELD;
    end else if (do_reset) begin
      state <= hpsa_pkg::HPSA_HELD; // [RULE_14]
    end else begin
      case (state)
        hpsa_pkg::HPSA_HELD: begin
          if (do_clear) begin
            state <= hpsa_pkg::HPSA_IDLE; // [RULE_11]
          end
        end
        hpsa_pkg::HPSA_IDLE: begin
          if (do_start) begin
            state <= hpsa_pkg::HPSA_WAKE_SEG; // [RULE_12] [RULE_20]
          end
        end
        hpsa_pkg::HPSA_WAKE_SEG: begin
          if (word_valid) begin
            state <= hpsa_pkg::HPSA_WAKE_OFF; // [RULE_03]
          end
        end
        hpsa_pkg::HPSA_WAKE_OFF: begin
          if (word_valid) begin
            state <= hpsa_pkg::HPSA_RUN;
          end
        end
        hpsa_pkg::HPSA_RUN: begin
          state <= hpsa_pkg::HPSA_RUN;
        end
        default: begin
          state <= hpsa_pkg::HPSA_HELD;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // strobes to the command engine
  always_ff @(posedge clk) begin
    if (hard_rst || do_reset) begin
      diag_start <= 1'b0;
      wake_fetch <= 1'b0;
      iopb_fetch <= 1'b0;
      busy_clear <= 1'b0;
    end else begin
      diag_start <= (state == hpsa_pkg::HPSA_HELD) && do_clear; // [RULE_15]
      wake_fetch <= (state == hpsa_pkg::HPSA_IDLE) && do_start; // [RULE_06]
      iopb_fetch <= (state == hpsa_pkg::HPSA_RUN) && do_start; // [RULE_13]
      busy_clear <= (state == hpsa_pkg::HPSA_WAKE_OFF) &&
        word_valid; // [RULE_12]
    end
  end

  // mode follows every start outside reset hold, so starts may mix shifts
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      shift_large <= 1'b0;
    end else if (do_start && !ctrl_reset) begin
      shift_large <= (fn == `HPSA_FN_START24); // [RULE_04] [RULE_05] [RULE_07]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address conversion, 24-bit wrap
  function automatic logic [23:0] seg_conv(input logic [15:0] seg,
                                           input logic [15:0] off,
                                           input logic big);
    logic [23:0] base;
    base = big ? {seg, 8'h00} : {4'h0, seg, 4'h0}; // [RULE_02]
    return base + {8'h00, off}; // [RULE_22]
  endfunction

  logic [15:0] wake_seg_v;
  // wake-up conversion uses the mode of the start being taken
  assign wake_seg_v = strap_s1;
  always_ff @(posedge clk) begin
    if (hard_rst || do_reset) begin
      mem_addr <= 24'h000000;
      mem_addr_valid <= 1'b0;
    end else if ((state == hpsa_pkg::HPSA_IDLE) && do_start) begin
      mem_addr <= seg_conv(wake_seg_v, 16'h0000,
                           fn == `HPSA_FN_START24); // [RULE_06] [RULE_01]
      mem_addr_valid <= 1'b1;
    end else if (cvt_req && (state == hpsa_pkg::HPSA_RUN)) begin
      mem_addr <= seg_conv(cvt_seg, cvt_off, shift_large); // [RULE_01]
      mem_addr_valid <= 1'b1;
    end else begin
      mem_addr_valid <= 1'b0;
    end
  end

  // channel control block pointer: offset word then segment word
  // the offset word stays in chan_off; the segment word is converted at once, not stored
  logic [15:0] chan_off;
  always_ff @(posedge clk) begin
    if (hard_rst || do_reset) begin
      chan_off <= 16'h0000;
      channel_control_block_addr <= 24'h000000;
      channel_control_block_valid <= 1'b0;
    end else if (word_valid && (state == hpsa_pkg::HPSA_WAKE_SEG)) begin
      chan_off <= word_data; // [RULE_03]
    end else if (word_valid && (state == hpsa_pkg::HPSA_WAKE_OFF)) begin
      channel_control_block_addr <=
        seg_conv(word_data, chan_off, shift_large); // [RULE_20]
      channel_control_block_valid <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt: set wins over clear in the same cycle
  logic int_set;
  assign int_set = !ctrl_reset && ((ev_cmd_done && !ev_cmd_suppress) ||
    ev_seek_done || ev_media_change); // [RULE_21]
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      int_pending <= 1'b0;
    end else if (int_set && !do_reset) begin
      int_pending <= 1'b1;
    end else if (do_clear || do_reset) begin
      int_pending <= 1'b0; // [RULE_10] [RULE_17]
    end
  end
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      int_out_n <= 8'hFF;
    end else begin
      int_out_n <= ~({7'h00, int_set || (int_pending &&
        !(do_clear || do_reset))} << jmp_s1); // [RULE_16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_clear_seen;
    do_clear && !int_set;
  endsequence
  property p_clear_drops;
    @(posedge clk) disable iff (!nrst) s_clear_seen |=> !int_pending;
  endproperty
  a_clear_drops: assert property (p_clear_drops) // [RULE_10]
    else $error("interrupt survived clear");
  property p_held_until_clear;
    @(posedge clk) disable iff (!nrst)
      ctrl_reset && !do_clear |=> ctrl_reset;
  endproperty
  a_held_until_clear: assert property (p_held_until_clear) // [RULE_11]
    else $error("reset released without clear");
  property p_reset_now;
    @(posedge clk) disable iff (!nrst) do_reset |=> ctrl_reset;
  endproperty
  a_reset_now: assert property (p_reset_now) // [RULE_14]
    else $error("reset write not immediate");
  property p_mode_24;
    @(posedge clk) disable iff (!nrst)
      do_start && !ctrl_reset && fn == `HPSA_FN_START24 |=> shift_large;
  endproperty
  a_mode_24: assert property (p_mode_24) // [RULE_05]
    else $error("03H start did not select 8-bit shift");
  property p_mode_20;
    @(posedge clk) disable iff (!nrst)
      do_start && !ctrl_reset && fn == `HPSA_FN_START20 |=> !shift_large;
  endproperty
  a_mode_20: assert property (p_mode_20) // [RULE_04]
    else $error("01H start did not select 4-bit shift");
  property p_wake_addr;
    @(posedge clk) disable iff (!nrst)
      (state == hpsa_pkg::HPSA_IDLE) && do_start && fn == `HPSA_FN_START20
      |=> mem_addr == {4'h0, $past(strap_s1), 4'h0};
  endproperty
  a_wake_addr: assert property (p_wake_addr) // [RULE_06]
    else $error("wake-up address wrong");
  property p_int_sticky;
    @(posedge clk) disable iff (!nrst)
      int_pending && !do_clear && !do_reset && init_s[1] |=> int_pending;
  endproperty
  a_int_sticky: assert property (p_int_sticky) // [RULE_17]
    else $error("interrupt dropped without cause");
  property p_one_line;
    @(posedge clk) disable iff (!nrst) $onehot0(~int_out_n);
  endproperty
  a_one_line: assert property (p_one_line) // [RULE_16]
    else $error("more than one interrupt line asserted");
  property p_wake_once;
    @(posedge clk) disable iff (!nrst)
      wake_fetch |=> !wake_fetch [*8];
  endproperty
  a_wake_once: assert property (p_wake_once) // [RULE_20]
    else $error("wake-up block fetched twice");

endmodule

// *** src/hpsa_pkg.sv ***
// types for the host port segment addressing block
// assumes hpsa_cfg.svh is on the include path
package hpsa_pkg;
  typedef enum logic [2:0] {
    HPSA_HELD = 3'h0,
    HPSA_IDLE = 3'h1,
    HPSA_WAKE_SEG = 3'h3,
    HPSA_WAKE_OFF = 3'h2,
    HPSA_RUN = 3'h6
  } hpsa_state_e;
endpackage
